// ---- include/imuod_defines.svh ----
// Constants for the inertial output register bank: register byte addresses,
// field positions, timing figures and scaling for the delta angle path.
// Assumes inclusion by the package and design files through the include path.
`ifndef IMUOD_DEFINES_SVH
`define IMUOD_DEFINES_SVH

// Register byte addresses on the serial port (16-bit registers, even address).
`define IMUOD_ADDR_ACC_X_LO    7'h10
`define IMUOD_ADDR_ACC_X_HI    7'h12
`define IMUOD_ADDR_ACC_Y_LO    7'h14
`define IMUOD_ADDR_ACC_Y_HI    7'h16
`define IMUOD_ADDR_ACC_Z_LO    7'h18
`define IMUOD_ADDR_ACC_Z_HI    7'h1A
`define IMUOD_ADDR_TEMP        7'h1C
`define IMUOD_ADDR_STAMP       7'h1E
`define IMUOD_ADDR_COUNT       7'h22
`define IMUOD_ADDR_DA_X_LO     7'h24
`define IMUOD_ADDR_DA_X_HI     7'h26
`define IMUOD_ADDR_DA_Y_LO     7'h28
`define IMUOD_ADDR_DA_Y_HI     7'h2A
`define IMUOD_ADDR_DA_Z_LO     7'h2C
`define IMUOD_ADDR_DA_Z_HI     7'h2E

// Word values and field positions.
`define IMUOD_ZERO16           16'h0000
`define IMUOD_MAX16            16'hFFFF
`define IMUOD_ONE16            16'h0001
`define IMUOD_SYNC_MODE_HI     4
`define IMUOD_SYNC_MODE_LO     2
`define IMUOD_SYNC_SCALED      3'h2
`define IMUOD_RD_BIT           15
`define IMUOD_ADDR_HI          14
`define IMUOD_ADDR_LO          8
`define IMUOD_FRAME_BITS       5'h10

// Timing: clock rate, stamp unit and internal sample rate.
`define IMUOD_CLK_HZ           125000000
`define IMUOD_CLK_PERIOD_PS    8000
`define IMUOD_STAMP_LSB_PS     49020000
`define IMUOD_SAMPLE_RATE_SPS  2000
`define IMUOD_STAMP_CYCLES     (`IMUOD_STAMP_LSB_PS / `IMUOD_CLK_PERIOD_PS)
`define IMUOD_SAMPLE_CYCLES    (`IMUOD_CLK_HZ / `IMUOD_SAMPLE_RATE_SPS)

// Delta angle path: accumulator width, variant gains and output shift.
`define IMUOD_ACC_W            50
`define IMUOD_PROD_W           53
`define IMUOD_DA_SHIFT         16
`define IMUOD_DA_GAIN_360      3'h6
`define IMUOD_DA_GAIN_720      3'h3
`define IMUOD_DA_GAIN_2160     3'h1
`define IMUOD_VARIANT_360      2'h0
`define IMUOD_VARIANT_720      2'h1

`endif

// ---- include/imuod_pkg.sv ----
// Types shared by the output register bank and its delta angle integrator.
// Assumes imuod_defines.svh is reachable on the include path.
`include "imuod_defines.svh"

package imuod_pkg;

    // Serial port frame state, one-hot.
    typedef enum logic [1:0] {
        IMUOD_SPI_IDLE = 2'b01,
        IMUOD_SPI_XFER = 2'b10
    } imuod_spi_state_t;

    typedef logic signed [31:0] imuod_word32_t;
    typedef logic        [15:0] imuod_word16_t;
    typedef logic signed [`IMUOD_ACC_W-1:0] imuod_acc_t;

endpackage : imuod_pkg

// ---- rtl/imuod_delta_integ.sv ----
// Trapezoidal delta angle integrator for three gyroscope axes.
// Assumes gyro words come from logic on clk and sample_tick is one cycle wide.
`include "imuod_defines.svh"

module imuod_delta_integ (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   sample_tick,
    input  wire imuod_pkg::imuod_word32_t gyro_x,
    input  wire imuod_pkg::imuod_word32_t gyro_y,
    input  wire imuod_pkg::imuod_word32_t gyro_z,
    input  wire logic [15:0]            decimation_setting,
    output logic                        update_done,
    output imuod_pkg::imuod_acc_t       sum_x,
    output imuod_pkg::imuod_acc_t       sum_y,
    output imuod_pkg::imuod_acc_t       sum_z
);
    import imuod_pkg::*;

    logic [15:0]   samp_cnt;
    logic [15:0]   next_samp_cnt;
    logic          next_update_done;
    logic          last_sample;
    imuod_word32_t gyro_in [3];
    imuod_word32_t prev    [3];
    imuod_acc_t    acc     [3];
    imuod_acc_t    res     [3];
    imuod_acc_t    pair_w  [3];

    assign gyro_in[0] = gyro_x;
    assign gyro_in[1] = gyro_y;
    assign gyro_in[2] = gyro_z;
    assign sum_x      = res[0];
    assign sum_y      = res[1];
    assign sum_z      = res[2];

    // A period closes after setting plus one samples; >= also recovers when
    // software lowers the setting in the middle of a period.
    // decimation plus one
    assign last_sample = (samp_cnt >= decimation_setting);

    // Sample counter within the decimation period.
    always_comb begin
        next_samp_cnt    = samp_cnt;
        next_update_done = 1'b0;
        if (sample_tick) begin
            if (last_sample) begin
                next_samp_cnt    = `IMUOD_ZERO16;
                next_update_done = 1'b1;
            end else begin
                next_samp_cnt = samp_cnt + `IMUOD_ONE16;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            samp_cnt    <= `IMUOD_ZERO16;
            update_done <= 1'b0;
        end else begin
            samp_cnt    <= next_samp_cnt;
            update_done <= next_update_done;
        end
    end

    // Per-axis accumulation of adjacent sample pairs; the 1/(2 fs) factor is
    // folded into the output scaling so no divider is needed here.
    for (genvar a = 0; a < 3; a++) begin : gen_axis
        imuod_word32_t next_prev;
        imuod_acc_t    next_acc;
        imuod_acc_t    next_res;

        assign pair_w[a] = imuod_acc_t'(gyro_in[a]) + imuod_acc_t'(prev[a]);

        always_comb begin
            next_prev = prev[a];
            next_acc  = acc[a];
            next_res  = res[a];
            if (sample_tick) begin
                next_prev = gyro_in[a];
                if (last_sample) begin
                    next_res = acc[a] + pair_w[a];
                    next_acc = '0;
                end else begin
                    next_acc = acc[a] + pair_w[a];
                end
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                prev[a] <= '0;
                acc[a]  <= '0;
                res[a]  <= '0;
            end else begin
                prev[a] <= next_prev;
                acc[a]  <= next_acc;
                res[a]  <= next_res;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    done_after_last_a: assert property (
        sample_tick && last_sample |=> update_done && samp_cnt == `IMUOD_ZERO16)
        else $error("period did not close after setting plus one samples");

    single_pair_a: assert property (
        sample_tick && decimation_setting == `IMUOD_ZERO16
        |=> res[0] == $past(acc[0]) + $past(pair_w[0]))
        else $error("delta sum is not the adjacent pair sum");

endmodule : imuod_delta_integ

// ---- rtl/imuod_out_regs.sv ----
// Output register bank of the inertial unit: accelerometer, temperature,
// sync time stamp, update counter and delta angle words, read over SPI.
// Assumes sensor words come from logic on clk; SPI and sync pins are async.
`include "imuod_defines.svh"

module imuod_out_regs #(
    parameter int unsigned SAMPLE_CYCLES = `IMUOD_SAMPLE_CYCLES,
    parameter int unsigned STAMP_CYCLES  = `IMUOD_STAMP_CYCLES,
    parameter logic [1:0]  DA_VARIANT    = `IMUOD_VARIANT_360
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     spi_sclk,
    input  wire logic                     spi_cs_n,
    input  wire logic                     spi_mosi,
    output logic                          spi_miso,
    output logic                          spi_miso_oe_n,
    input  wire logic                     sync_pin,
    input  wire imuod_pkg::imuod_word32_t accel_x,
    input  wire imuod_pkg::imuod_word32_t accel_y,
    input  wire imuod_pkg::imuod_word32_t accel_z,
    input  wire imuod_pkg::imuod_word16_t temperature,
    input  wire imuod_pkg::imuod_word32_t gyro_x,
    input  wire imuod_pkg::imuod_word32_t gyro_y,
    input  wire imuod_pkg::imuod_word32_t gyro_z,
    input  wire imuod_pkg::imuod_word16_t decimation_setting,
    input  wire imuod_pkg::imuod_word16_t miscellaneous_control,
    output logic                          new_sample_indicator
);
    import imuod_pkg::*;

    // Pin synchronisers: bit 0 sclk, 1 cs_n, 2 mosi, 3 sync.
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       sclk_d;
    logic       sync_d;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta <= 4'h3;
            pin_sync <= 4'h3;
            sclk_d   <= 1'b1;
            sync_d   <= 1'b0;
        end else begin
            pin_meta <= {sync_pin, spi_mosi, spi_cs_n, spi_sclk};
            pin_sync <= pin_meta;
            sclk_d   <= pin_sync[0];
            sync_d   <= pin_sync[3];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sync_rise;
    logic scaled_mode;
    assign sclk_rise   = pin_sync[0] & ~sclk_d;
    assign sclk_fall   = ~pin_sync[0] & sclk_d;
    assign sync_rise   = pin_sync[3] & ~sync_d;
    assign scaled_mode = (miscellaneous_control[`IMUOD_SYNC_MODE_HI:`IMUOD_SYNC_MODE_LO]
                          == `IMUOD_SYNC_SCALED);

    // Internal sample clock and sync time stamp prescaler.
    logic [31:0]   samp_div;
    logic [31:0]   next_samp_div;
    logic          sample_tick;
    logic [31:0]   stamp_div;
    logic [31:0]   next_stamp_div;
    imuod_word16_t stamp;
    imuod_word16_t next_stamp;

    assign sample_tick = (samp_div == SAMPLE_CYCLES - 1);

    // The stamp saturates rather than wraps, so a lost sync reads as old.
    always_comb begin
        next_samp_div  = sample_tick ? '0 : samp_div + 32'h1;
        next_stamp_div = stamp_div;
        next_stamp     = stamp;
        if (scaled_mode && sync_rise) begin
            next_stamp_div = '0;
            next_stamp     = `IMUOD_ZERO16;
        end else if (stamp_div == STAMP_CYCLES - 1) begin
            next_stamp_div = '0;
            if (stamp != `IMUOD_MAX16) begin
                next_stamp = stamp + `IMUOD_ONE16;
            end
        end else begin
            next_stamp_div = stamp_div + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            samp_div  <= '0;
            stamp_div <= '0;
            stamp     <= `IMUOD_ZERO16;
        end else begin
            samp_div  <= next_samp_div;
            stamp_div <= next_stamp_div;
            stamp     <= next_stamp;
        end
    end

    // Delta angle integration over the decimation period.
    logic       update_done;
    imuod_acc_t sum_x;
    imuod_acc_t sum_y;
    imuod_acc_t sum_z;

    imuod_delta_integ u_integ (
        .clk                (clk),
        .srst               (srst),
        .sample_tick        (sample_tick),
        .gyro_x             (gyro_x),
        .gyro_y             (gyro_y),
        .gyro_z             (gyro_z),
        .decimation_setting (decimation_setting),
        .update_done        (update_done),
        .sum_x              (sum_x),
        .sum_y              (sum_y),
        .sum_z              (sum_z)
    );

    // Variant gain stands for full scale over two to the thirty-first; smaller
    // range gives more counts per degree.
    logic [2:0]                da_gain;
    logic signed [`IMUOD_PROD_W-1:0] prod [3];
    imuod_word32_t             da_word [3];
    assign da_gain = (DA_VARIANT == `IMUOD_VARIANT_360) ? `IMUOD_DA_GAIN_360 :
                     (DA_VARIANT == `IMUOD_VARIANT_720) ? `IMUOD_DA_GAIN_720 :
                                                          `IMUOD_DA_GAIN_2160;
    assign prod[0] = `IMUOD_PROD_W'(sum_x) * $signed({1'b0, da_gain});
    assign prod[1] = `IMUOD_PROD_W'(sum_y) * $signed({1'b0, da_gain});
    assign prod[2] = `IMUOD_PROD_W'(sum_z) * $signed({1'b0, da_gain});
    for (genvar a = 0; a < 3; a++) begin : gen_scale
        assign da_word[a] = prod[a][`IMUOD_DA_SHIFT+31 -: 32];
    end

    // Output registers load together on each data update.
    imuod_word32_t acc_reg [3];
    imuod_word32_t da_reg  [3];
    imuod_word16_t internal_temperature;
    imuod_word16_t sync_elapsed_time;
    imuod_word16_t update_counter;
    imuod_word32_t next_acc_reg [3];
    imuod_word32_t next_da_reg  [3];
    imuod_word16_t next_temp;
    imuod_word16_t next_elapsed;
    imuod_word16_t next_counter;

    always_comb begin
        next_acc_reg = acc_reg;
        next_da_reg  = da_reg;
        next_temp    = internal_temperature;
        next_elapsed = sync_elapsed_time;
        next_counter = update_counter;
        if (update_done) begin
            next_acc_reg = '{accel_x, accel_y, accel_z};
            next_da_reg  = da_word;
            next_temp    = temperature;
            next_elapsed = scaled_mode ? stamp : `IMUOD_ZERO16;
            next_counter = update_counter + `IMUOD_ONE16;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_reg              <= '{default: '0};
            da_reg               <= '{default: '0};
            internal_temperature <= `IMUOD_ZERO16;
            sync_elapsed_time    <= `IMUOD_ZERO16;
            update_counter       <= `IMUOD_ZERO16;
            new_sample_indicator <= 1'b0;
        end else begin
            acc_reg              <= next_acc_reg;
            da_reg               <= next_da_reg;
            internal_temperature <= next_temp;
            sync_elapsed_time    <= next_elapsed;
            update_counter       <= next_counter;
            new_sample_indicator <= update_done;
        end
    end

    // Read decode; bit 0 of the address is ignored, unmapped reads zero.
    logic [6:0]    rd_addr;
    imuod_word16_t rd_value;
    always_comb begin
        unique case ({rd_addr[6:1], 1'b0})
            `IMUOD_ADDR_ACC_X_LO: rd_value = acc_reg[0][15:0];
            `IMUOD_ADDR_ACC_Y_LO: rd_value = acc_reg[1][15:0];
            `IMUOD_ADDR_ACC_Z_LO: rd_value = acc_reg[2][15:0];
            `IMUOD_ADDR_ACC_X_HI: rd_value = acc_reg[0][31:16];
            `IMUOD_ADDR_ACC_Y_HI: rd_value = acc_reg[1][31:16];
            `IMUOD_ADDR_ACC_Z_HI: rd_value = acc_reg[2][31:16];
            `IMUOD_ADDR_TEMP:     rd_value = internal_temperature;
            `IMUOD_ADDR_STAMP:    rd_value = sync_elapsed_time;
            `IMUOD_ADDR_COUNT:    rd_value = update_counter;
            `IMUOD_ADDR_DA_X_LO:  rd_value = da_reg[0][15:0];
            `IMUOD_ADDR_DA_X_HI:  rd_value = da_reg[0][31:16];
            `IMUOD_ADDR_DA_Y_LO:  rd_value = da_reg[1][15:0];
            `IMUOD_ADDR_DA_Y_HI:  rd_value = da_reg[1][31:16];
            `IMUOD_ADDR_DA_Z_LO:  rd_value = da_reg[2][15:0];
            `IMUOD_ADDR_DA_Z_HI:  rd_value = da_reg[2][31:16];
            default:              rd_value = `IMUOD_ZERO16;
        endcase
    end

    // SPI slave, mode 3, 16-bit frames. A read command in one frame returns
    // its data in the next frame; writes are ignored as every word is read-only.
    imuod_spi_state_t spi_state;
    imuod_spi_state_t next_spi_state;
    logic [4:0]       bit_cnt;
    logic [4:0]       next_bit_cnt;
    imuod_word16_t    rx_shift;
    imuod_word16_t    next_rx_shift;
    imuod_word16_t    tx_shift;
    imuod_word16_t    next_tx_shift;
    imuod_word16_t    tx_word;
    imuod_word16_t    next_tx_word;
    logic             frame_read;

    assign rd_addr    = rx_shift[`IMUOD_ADDR_HI:`IMUOD_ADDR_LO];
    assign frame_read = (spi_state == IMUOD_SPI_XFER) && pin_sync[1]
                        && (bit_cnt == `IMUOD_FRAME_BITS) && !rx_shift[`IMUOD_RD_BIT];

    always_comb begin
        next_spi_state = spi_state;
        next_bit_cnt   = bit_cnt;
        next_rx_shift  = rx_shift;
        next_tx_shift  = tx_shift;
        next_tx_word   = tx_word;
        unique case (spi_state)
            IMUOD_SPI_IDLE: begin
                if (!pin_sync[1]) begin
                    next_spi_state = IMUOD_SPI_XFER;
                    next_bit_cnt   = '0;
                    next_tx_shift  = tx_word;
                end
            end
            IMUOD_SPI_XFER: begin
                if (pin_sync[1]) begin
                    next_spi_state = IMUOD_SPI_IDLE;
                    // Short or long frames are dropped and clear the reply.
                    next_tx_word   = frame_read ? rd_value : `IMUOD_ZERO16;
                end else if (sclk_rise) begin
                    next_rx_shift = {rx_shift[14:0], pin_sync[2]};
                    next_bit_cnt  = bit_cnt + 5'h1;
                end else if (sclk_fall && bit_cnt != '0) begin
                    next_tx_shift = {tx_shift[14:0], 1'b0};
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            spi_state <= IMUOD_SPI_IDLE;
            bit_cnt   <= '0;
            rx_shift  <= `IMUOD_ZERO16;
            tx_shift  <= `IMUOD_ZERO16;
            tx_word   <= `IMUOD_ZERO16;
        end else begin
            spi_state <= next_spi_state;
            bit_cnt   <= next_bit_cnt;
            rx_shift  <= next_rx_shift;
            tx_shift  <= next_tx_shift;
            tx_word   <= next_tx_word;
        end
    end

    assign spi_miso      = tx_shift[15];
    assign spi_miso_oe_n = (spi_state == IMUOD_SPI_IDLE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_update;
        update_done;
    endsequence

    sequence s_read_end;
        frame_read;
    endsequence

    counter_incr_a: assert property (s_update |=> update_counter ==
        16'($past(update_counter) + `IMUOD_ONE16))
        else $error("update counter did not step by one");

    counter_wrap_a: assert property (
        s_update ##0 update_counter == `IMUOD_MAX16 |=> update_counter == `IMUOD_ZERO16)
        else $error("update counter did not wrap to zero");

    counter_reset_a: assert property ($fell(srst) |-> update_counter == `IMUOD_ZERO16)
        else $error("update counter not zero after reset");

    accel_pair_a: assert property (s_update |=> acc_reg[1] == $past(accel_y)
        && acc_reg[2][15:0] == $past(accel_z[15:0]))
        else $error("accel halves not loaded together");

    delta_hold_a: assert property (!update_done |=> $stable(da_reg[0])
        && $stable(update_counter))
        else $error("output words changed between updates");

    temp_load_a: assert property (s_update |=> internal_temperature == $past(temperature))
        else $error("temperature word not loaded at update");

    stamp_restart_a: assert property (scaled_mode && sync_rise |=> stamp == `IMUOD_ZERO16)
        else $error("time stamp did not restart on sync edge");

    read_reply_a: assert property (s_read_end |=> tx_word == $past(rd_value))
        else $error("read reply not latched at frame end");

    tick_single_a: assert property (sample_tick |=> !sample_tick && samp_div == '0)
        else $error("sample clock tick not single");

endmodule : imuod_out_regs

// ---- tb/imuod_host.sv ----
// Host model: SPI mode 3 master sending 16-bit frames.
// Assumes the device returns a read reply in the frame that follows.
module imuod_host (
    input  wire logic clk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock and select idle high between frames.
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // The idle data line toggles so no stale bit can pass for a real one.
    always @(negedge clk) begin
        if (spi_cs_n) begin
            spi_mosi <= ~spi_mosi;
        end
    end

    // One frame with half periods of 8 clk; an undriven reply bit reads unknown.
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] reply);
        @(negedge clk);
        spi_cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_mosi = cmd[i];
            repeat (8) @(negedge clk);
            spi_sclk = 1'b1;
            reply[i] = spi_miso_oe_n ? 1'bx : spi_miso;
            repeat (8) @(negedge clk);
        end
        spi_cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : imuod_host

// ---- tb/tb.sv ----
// Self-checking bench for the output register bank, read through the host model.
// Assumes short sample and stamp counts so updates come every 1280 cycles at the default setting.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import imuod_pkg::*;

    logic          clk = 1'b0, srst = 1'b1, sclk, cs_n, mosi, miso, oe_n, nsi;
    logic          sync_pin = 1'b0;
    imuod_word32_t accel_x = '0, accel_y = '0, accel_z = '0;
    imuod_word32_t gyro_x = '0, gyro_y = '0, gyro_z = '0;
    imuod_word16_t temperature = '0, dec = 16'h003F, misc = 16'h0000;
    logic [15:0]   pulses, r;
    int            err_count = 0, checks_done = 0, cycles = 0, t_pulse = 0, t0;
    logic [6:0]    u_addr [13] = '{7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h1A, 7'h1C, 7'h1E,
                                   7'h24, 7'h26, 7'h20, 7'h30, 7'h7E};
    logic [15:0]   u_dec [3] = '{16'h0000, 16'h0003, 16'h0005};

    always #4 clk = ~clk;

    imuod_out_regs #(.SAMPLE_CYCLES(20), .STAMP_CYCLES(3), .DA_VARIANT(2'h0)) u_imuod_out_regs (
        .clk(clk), .srst(srst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(oe_n), .sync_pin(sync_pin), .accel_x(accel_x),
        .accel_y(accel_y), .accel_z(accel_z), .temperature(temperature), .gyro_x(gyro_x),
        .gyro_y(gyro_y), .gyro_z(gyro_z), .decimation_setting(dec),
        .miscellaneous_control(misc), .new_sample_indicator(nsi));

    imuod_host u_imuod_host (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(oe_n));

    // Counts updates seen at the pin; a hang ends the run as a failure.
    always @(posedge clk) begin
        pulses <= srst ? 16'h0000 : pulses + {15'h0000, nsi};
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            complete_run();
        end
    end

    // Expected register contents; the delta word uses the gain 6, shift 16 scaling.
    function automatic logic [15:0] expect_word(input logic [6:0] a);
        longint da;
        da = (longint'(gyro_x) * 2 * (longint'(dec) + 1) * 6) >>> 16;
        case (a)
            7'h10: return accel_x[15:0];
            7'h12: return accel_x[31:16];
            7'h14: return accel_y[15:0];
            7'h16: return accel_y[31:16];
            7'h18: return accel_z[15:0];
            7'h1A: return accel_z[31:16];
            7'h1C: return temperature;
            7'h24: return da[15:0];
            7'h26: return da[31:16];
            default: return 16'h0000;
        endcase
    endfunction : expect_word

    task automatic check_eq(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_eq

    task automatic check_rng(input string name, input int lo, input int hi, input logic [15:0] got);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_count++;
            $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_rng

    // Command frame, then a frame that carries the reply back.
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        logic [15:0] unused;
        u_imuod_host.xfer({1'b0, a, 8'h00}, unused);
        u_imuod_host.xfer(16'h0000, d);
    endtask : rd

    task automatic wait_pulse();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (nsi !== 1'b1 && n < 5000);
        if (n == 5000) err_count++;
        t_pulse = cycles;
    endtask : wait_pulse

    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    initial begin
        void'($urandom(63));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        rd(7'h22, r);
        check_eq("update_counter", 16'h0000, r);
        // Random words, plus a zero and all-ones corner, held over a full window.
        for (int k = 0; k < 3; k++) begin
            accel_x = (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'hFFFF_FFFF : $urandom;
            {accel_y, accel_z} = {$urandom, $urandom};
            temperature = $urandom;
            gyro_x = $signed($urandom_range(20000, 0)) - 10000;
            {gyro_y, gyro_z} = {$urandom, $urandom};
            wait_pulse();
            wait_pulse();
            foreach (u_addr[i]) begin
                rd(u_addr[i], r);
                check_eq("register", expect_word(u_addr[i]), r);
            end
            // Start just after an update so that none lands between latch and compare.
            wait_pulse();
            rd(7'h22, r);
            check_eq("update_counter", pulses, r);
        end
        // Update spacing follows the decimation setting.
        // rate measured at settings 0, 3 and 5
        foreach (u_dec[i]) begin
            dec = u_dec[i];
            wait_pulse();
            wait_pulse();
            t0 = t_pulse;
            wait_pulse();
            check_eq("update_period", 16'((dec + 1) * 20), 16'(t_pulse - t0));
        end
        // Scaled sync mode: stamp counts 3-cycle units from the pulse to the update.
        dec = 16'h003F;
        misc = 16'h0008;
        wait_pulse();
        wait_pulse();
        sync_pin = 1'b1;
        repeat (2) @(negedge clk);
        sync_pin = 1'b0;
        wait_pulse();
        rd(7'h1E, r);
        check_rng("sync_elapsed_time", 420, 428, r);
        // A reset in mid-run must bring the update counter back to zero.
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        rd(7'h22, r);
        check_eq("update_counter", 16'h0000, r);
        complete_run();
    end

endmodule : tb
